// [inc/hpp_defines.svh]
// constants for the parallel host port address and control block
`ifndef HPP_DEFINES_SVH
`define HPP_DEFINES_SVH
`define HPP_AW          5
`define HPP_DW          8
`define HPP_NREG        32
`define HPP_ADDR_ZERO   5'h00
`define HPP_DATA_ZERO   8'h00
`define HPP_WAIT_CYC    3'h2
`define HPP_ONE3        3'h1
`define HPP_ZERO3       3'h0
`endif

// [inc/hpp_pkg.sv]
// types for the parallel host port
package hpp_pkg;
	typedef enum logic [1:0] {
		STYLE_DIRECT  = 2'h0,
		STYLE_MUX_ALE = 2'h1,
		STYLE_STROBE  = 2'h2,
		STYLE_HWCTRL  = 2'h3
	} bus_style_t;
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_WAIT = 3'h1,
		DS_ACK  = 3'h2,
		DS_HOLD = 3'h3
	} dev_state_t;
	typedef enum logic [2:0] {
		HS_IDLE = 3'h0,
		HS_ADDR = 3'h1,
		HS_STRB = 3'h2,
		HS_DATA = 3'h3,
		HS_DONE = 3'h4
	} host_state_t;
endpackage

// [inc/hpp_if.sv]
// pin bundle between host and device ends of the parallel port
`timescale 1ns/1ps
`include "hpp_defines.svh"
interface hpp_if;
	logic [`HPP_AW-1:0] register_address_inputs;
	logic               chip_sel_n;
	logic               addr_latch_en;   // shares pin with strobe
	logic               address_strobe_n;
	logic               data_strobe_n;
	logic               rd_not_wr;
	logic               xfer_ack_n;
	logic [`HPP_DW-1:0] host_data_o;
	logic               host_data_oe;
	logic [`HPP_DW-1:0] dev_data_o;
	logic               dev_data_oe;
	// resolved level of the shared data lines
	logic [`HPP_DW-1:0] host_data_lines;
	assign host_data_lines = host_data_oe ? host_data_o :
		(dev_data_oe ? dev_data_o : `HPP_DATA_ZERO);
	modport host (output register_address_inputs, chip_sel_n, addr_latch_en,
		address_strobe_n, data_strobe_n, rd_not_wr, host_data_o, host_data_oe,
		input xfer_ack_n, host_data_lines);
	modport dev (input register_address_inputs, chip_sel_n, addr_latch_en,
		address_strobe_n, data_strobe_n, rd_not_wr, host_data_o, host_data_oe,
		host_data_lines, output xfer_ack_n, dev_data_o, dev_data_oe);
endinterface

// [rtl/hpp_addr_latch.sv]
// address capture for the latch-enable bus style; other styles pass the direct address pins
`timescale 1ns/1ps
`include "hpp_defines.svh"
module hpp_addr_latch
	import hpp_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// pins
	input  wire bus_style_t         style,
	input  wire logic [`HPP_AW-1:0] direct_addr,
	input  wire logic [`HPP_DW-1:0] lines,
	input  wire logic               ale,
	// captured address
	output logic [`HPP_AW-1:0]      addr
);
	logic [`HPP_AW-1:0] lat_q;
	logic [`HPP_AW-1:0] lat_d;

	// next latched address; follows lines while ale is high
	always_comb begin
		lat_d = lat_q;
		// value at falling ale edge kept
		// the host swaps lines to data as ale drops, so sample before the fall
		if (ale)
			lat_d = lines[`HPP_AW-1:0];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lat_q <= `HPP_ADDR_ZERO;
		end else begin
			lat_q <= lat_d;
		end
	end

	// mux styles use latched low bits
	assign addr = (style == STYLE_MUX_ALE) ? lat_q : direct_addr;
endmodule

// [rtl/hpp_host.sv]
// host end: drives one register access per request outside hardware-control style
`timescale 1ns/1ps
`include "hpp_defines.svh"
module hpp_host
	import hpp_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// user side
	input  wire bus_style_t         style,
	input  wire logic               req,
	input  wire logic               req_rd,
	input  wire logic [`HPP_AW-1:0] req_addr,
	input  wire logic [`HPP_DW-1:0] req_wdata,
	output logic                    done,
	output logic [`HPP_DW-1:0]      rdata,
	// pins
	hpp_if.host                     bus
);
	host_state_t        st_q, st_d;
	logic [`HPP_AW-1:0] a_q, a_d;
	logic [`HPP_DW-1:0] w_q, w_d, r_q, r_d;
	logic               rd_q, rd_d, done_q, done_d;
	logic               cs_q, cs_d, ale_q, ale_d, ds_q, ds_d, oe_q, oe_d;
	logic [`HPP_DW-1:0] do_q, do_d;

	// next state of the access sequencer
	always_comb begin
		st_d = st_q; a_d = a_q; w_d = w_q; r_d = r_q; rd_d = rd_q;
		done_d = 1'b0; cs_d = cs_q; ale_d = ale_q; ds_d = ds_q;
		oe_d = oe_q; do_d = do_q;
		unique case (st_q)
			HS_IDLE: begin
				if (req && style != STYLE_HWCTRL) begin
					a_d = req_addr; w_d = req_wdata; rd_d = req_rd;
					cs_d = 1'b0;
					ale_d = (style == STYLE_MUX_ALE);
					oe_d = (style == STYLE_MUX_ALE);
					do_d = {{(`HPP_DW-`HPP_AW){1'b0}}, req_addr};
					st_d = HS_ADDR;
				end
			end
			HS_ADDR: begin
				ale_d = (style == STYLE_STROBE) ? 1'b0 : 1'b0;
				oe_d = !rd_q;
				do_d = w_q;
				st_d = HS_STRB;
			end
			HS_STRB: begin
				ds_d = 1'b0;
				st_d = HS_DATA;
			end
			HS_DATA: begin
				if (!bus.xfer_ack_n) begin
					r_d = bus.host_data_lines;
					ds_d = 1'b1; cs_d = 1'b1; oe_d = 1'b0;
					st_d = HS_DONE;
				end
			end
			HS_DONE: begin
				done_d = 1'b1;
				st_d = HS_IDLE;
			end
			default: st_d = HS_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= HS_IDLE; a_q <= `HPP_ADDR_ZERO; w_q <= `HPP_DATA_ZERO;
			r_q <= `HPP_DATA_ZERO; rd_q <= 1'b0; done_q <= 1'b0;
			cs_q <= 1'b1; ale_q <= 1'b0; ds_q <= 1'b1; oe_q <= 1'b0;
			do_q <= `HPP_DATA_ZERO;
		end else begin
			st_q <= st_d; a_q <= a_d; w_q <= w_d; r_q <= r_d; rd_q <= rd_d;
			done_q <= done_d; cs_q <= cs_d; ale_q <= ale_d; ds_q <= ds_d;
			oe_q <= oe_d; do_q <= do_d;
		end
	end

	// pin drive; hardware-control ties address, ale and both strobe pins low
	always_comb begin
		bus.register_address_inputs = a_q;
		// mux styles wire address pins to shared lines
		if (style == STYLE_MUX_ALE)
			bus.register_address_inputs = bus.host_data_lines[`HPP_AW-1:0];
		if (style == STYLE_HWCTRL)
			bus.register_address_inputs = `HPP_ADDR_ZERO;
	end
	assign bus.addr_latch_en = (style == STYLE_MUX_ALE) ? ale_q : 1'b0;
	// strobe held low in hardware mode
	assign bus.address_strobe_n = (style == STYLE_STROBE) ? cs_q : 1'b0;
	assign bus.chip_sel_n    = cs_q;
	assign bus.data_strobe_n = (style == STYLE_HWCTRL) ? 1'b0 : ds_q;
	assign bus.rd_not_wr     = rd_q;
	assign bus.host_data_o   = do_q;
	assign bus.host_data_oe  = oe_q;
	assign done  = done_q;
	assign rdata = r_q;
endmodule

// [rtl/hpp_dev.sv]
// device end: address capture, register file, acknowledge
// Functional notes
// - host puts address on direct pins
// - muxed bus ties address pins to lines
// - address pins low in hardware mode
// - acknowledge low marks valid read data
// - acknowledge low marks write accepted
// - wait states only for back-to-back write
// - address latched on ale falling edge
// - ale held low in hardware mode
// - low address strobe marks valid address
// - address strobe low in hardware mode
// - muxed lines carry data and address
// - data lines bidirectional, direction by access
// - ignore bus while chip select high
// - data strobe times each transfer
`timescale 1ns/1ps
`include "hpp_defines.svh"
module hpp_dev
	import hpp_pkg::*;
(
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst,
	// user side
	input  wire bus_style_t         style,
	output logic                    wr_pulse,
	output logic [`HPP_AW-1:0]      wr_addr,
	output logic [`HPP_DW-1:0]      wr_data,
	// pins
	hpp_if.dev                      bus
);
	// ----------------------------------------
	// address capture
	// ----------------------------------------
	logic [`HPP_AW-1:0] addr;

	hpp_addr_latch u_latch (
		.clk         (clk),
		.rst         (rst),
		.style       (style),
		.direct_addr (bus.register_address_inputs),
		.lines       (bus.host_data_lines),
		.ale         (bus.addr_latch_en),
		.addr        (addr)
	);

	// ----------------------------------------
	// access sequencer
	// ----------------------------------------
	dev_state_t         st_q, st_d;
	logic [2:0]         wc_q, wc_d;
	logic               prev_q, prev_d;   // an access just finished
	logic               ack_q, ack_d, oe_q, oe_d, wp_q, wp_d;
	logic [`HPP_DW-1:0] do_q, do_d, wd_q, wd_d;
	logic [`HPP_AW-1:0] wa_q, wa_d;
	logic [`HPP_DW-1:0] regs_q [`HPP_NREG];
	logic               sel, valid_addr;

	// one-hot select of the addressed word
	function automatic logic hit(input logic [`HPP_AW-1:0] a, input int i);
		hit = (a == i[`HPP_AW-1:0]);
	endfunction

	assign sel = !bus.chip_sel_n && style != STYLE_HWCTRL;
	// strobe style needs low address strobe
	assign valid_addr = (style != STYLE_STROBE) || !bus.address_strobe_n;

	always_comb begin
		st_d = st_q; wc_d = wc_q; prev_d = prev_q; ack_d = ack_q;
		oe_d = oe_q; do_d = do_q; wp_d = 1'b0; wd_d = wd_q; wa_d = wa_q;
		unique case (st_q)
			DS_IDLE: begin
				if (sel && valid_addr && !bus.data_strobe_n) begin
					wa_d = addr;
					wd_d = bus.host_data_lines;
					// wait only for write after an access
					if (!bus.rd_not_wr && prev_q) begin
						wc_d = `HPP_WAIT_CYC;
						st_d = DS_WAIT;
					end else
						st_d = DS_ACK;
				end else if (!sel)
					prev_d = 1'b0;
			end
			DS_WAIT: begin
				wc_d = wc_q - `HPP_ONE3;
				if (wc_q == `HPP_ONE3)
					st_d = DS_ACK;
			end
			DS_ACK: begin
				if (bus.rd_not_wr) begin
					do_d = regs_q[wa_q];
					oe_d = 1'b1;
				end else
					wp_d = 1'b1;
				ack_d = 1'b0;
				st_d = DS_HOLD;
			end
			DS_HOLD: begin
				if (bus.data_strobe_n || bus.chip_sel_n) begin
					ack_d = 1'b1; oe_d = 1'b0; prev_d = 1'b1;
					st_d = DS_IDLE;
				end
			end
			default: st_d = DS_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= DS_IDLE; wc_q <= `HPP_ZERO3; prev_q <= 1'b0;
			ack_q <= 1'b1; oe_q <= 1'b0; do_q <= `HPP_DATA_ZERO;
			wp_q <= 1'b0; wd_q <= `HPP_DATA_ZERO; wa_q <= `HPP_ADDR_ZERO;
		end else begin
			st_q <= st_d; wc_q <= wc_d; prev_q <= prev_d; ack_q <= ack_d;
			oe_q <= oe_d; do_q <= do_d; wp_q <= wp_d; wd_q <= wd_d;
			wa_q <= wa_d;
		end
	end

	// ----------------------------------------
	// register storage
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < `HPP_NREG; gi++) begin : g_reg
			logic [`HPP_DW-1:0] r_d;
			always_comb begin
				r_d = regs_q[gi];
				if (wp_d && hit(wa_q, gi))
					r_d = wd_q;
			end
			always_ff @(posedge clk or posedge rst) begin
				if (rst)
					regs_q[gi] <= `HPP_DATA_ZERO;
				else
					regs_q[gi] <= r_d;
			end
		end
	endgenerate

	assign bus.xfer_ack_n  = ack_q;
	assign bus.dev_data_o  = do_q;
	assign bus.dev_data_oe = oe_q;
	assign wr_pulse = wp_q;
	assign wr_addr  = wa_q;
	assign wr_data  = wd_q;
endmodule

// [testbench/hpp_assertions.sv]
// pin-level protocol checker for the host and device ends
`timescale 1ns/1ps
`include "hpp_defines.svh"
module hpp_assertions (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst,
	// pins
	input wire logic               chip_sel_n,
	input wire logic               data_strobe_n,
	input wire logic               rd_not_wr,
	input wire logic               xfer_ack_n,
	input wire logic               host_data_oe,
	input wire logic               dev_data_oe,
	input wire logic [`HPP_DW-1:0] dev_data_o,
	input wire logic [`HPP_DW-1:0] host_data_lines
);
	// ----------------------------------------
	// acknowledge timing
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	ack_needs_sel_a: assert property (!xfer_ack_n |-> !$past(chip_sel_n) && !$past(data_strobe_n))
		else $error("ack without select and strobe");
	ack_stands_a: assert property (!xfer_ack_n && !data_strobe_n && !chip_sel_n |=> !xfer_ack_n)
		else $error("ack dropped while strobe held");
	ack_release_a: assert property (!xfer_ack_n && data_strobe_n |=> xfer_ack_n)
		else $error("ack held after strobe release");
	read_fast_a: assert property ($fell(data_strobe_n) && !chip_sel_n && rd_not_wr
		|-> ##[1:3] !xfer_ack_n)
		else $error("read acknowledged late");
	ack_bound_a: assert property ($fell(data_strobe_n) && !chip_sel_n |-> ##[1:6] !xfer_ack_n)
		else $error("access never acknowledged");
	idle_quiet_a: assert property (chip_sel_n && $past(chip_sel_n) |-> xfer_ack_n)
		else $error("ack while deselected");
	// ----------------------------------------
	// data line ownership
	// ----------------------------------------
	read_data_a: assert property (!xfer_ack_n && rd_not_wr && !data_strobe_n
		|-> dev_data_oe && host_data_lines == dev_data_o)
		else $error("read ack without device data");
	no_clash_a: assert property (!(host_data_oe && dev_data_oe))
		else $error("both ends drive the lines");
	// device lets go one cycle after the host deselects
	dev_rd_only_a: assert property (dev_data_oe |-> rd_not_wr && !$past(chip_sel_n))
		else $error("device drives outside a read");
	// main scenarios
	cov_read: cover property (!xfer_ack_n && rd_not_wr);
	cov_write: cover property (!xfer_ack_n && !rd_not_wr);
	cov_slow: cover property ($fell(data_strobe_n) ##1 xfer_ack_n [*3]);
endmodule

// [testbench/host_parallel_bus_address_ctrl_tb_top.sv]
// self-checking bench: host and device ends joined by the pin bundle
`timescale 1ns/1ps
`include "hpp_defines.svh"
module host_parallel_bus_address_ctrl_tb_top
	import hpp_pkg::*;
;
	bus_style_t         style = STYLE_DIRECT;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               req = 1'b0;
	logic               req_rd = 1'b0;
	logic [`HPP_AW-1:0] req_addr = 5'h00;
	logic [`HPP_DW-1:0] req_wdata = 8'h00;
	logic               done, wr_pulse, seen;
	logic [`HPP_AW-1:0] wr_addr, a, exp_a;
	logic [`HPP_DW-1:0] rdata, wr_data, d, exp_d;
	logic [`HPP_DW-1:0] mem [32];
	int                 failures = 0;
	int                 compares = 0;
	int                 wr_seen = 0;
	hpp_if bus ();
	// ----------------------------------------
	// ends under test and checker
	// ----------------------------------------
	hpp_host i_hpp_host (.clk(clk), .rst(rst), .style(style), .req(req), .req_rd(req_rd),
		.req_addr(req_addr), .req_wdata(req_wdata), .done(done), .rdata(rdata), .bus(bus));
	hpp_dev i_hpp_dev (.clk(clk), .rst(rst), .style(style), .wr_pulse(wr_pulse),
		.wr_addr(wr_addr), .wr_data(wr_data), .bus(bus));
	hpp_assertions u_chk (.clk(clk), .rst(rst), .chip_sel_n(bus.chip_sel_n),
		.data_strobe_n(bus.data_strobe_n), .rd_not_wr(bus.rd_not_wr),
		.xfer_ack_n(bus.xfer_ack_n), .host_data_oe(bus.host_data_oe),
		.dev_data_oe(bus.dev_data_oe), .dev_data_o(bus.dev_data_o),
		.host_data_lines(bus.host_data_lines));
	// free-running clock
	always #4 clk = ~clk;
	// ----------------------------------------
	// compare and verdict
	// ----------------------------------------
	task automatic check(string what, logic [7:0] exp, logic [7:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// every device write must match the pending access
	always @(posedge clk) begin
		if (wr_pulse === 1'b1) begin
			wr_seen++;
			check("wr_addr", {3'h0, exp_a}, {3'h0, wr_addr});
			check("wr_data", exp_d, wr_data);
		end
	end
	// one access; req is a one-cycle level taken in idle
	task automatic acc(logic rd, logic [4:0] ad, logic [7:0] dd);
		int n;
		n = wr_seen;
		exp_a = ad;
		exp_d = dd;
		@(posedge clk);
		req <= 1'b1;
		req_rd <= rd;
		req_addr <= ad;
		req_wdata <= dd;
		@(posedge clk);
		req <= 1'b0;
		repeat (40) if (done !== 1'b1) @(posedge clk);
		check("done", 8'h01, {7'h00, done});
		if (rd)
			check("rdata", mem[ad], rdata);
		else
			mem[ad] = dd;
		repeat (2) @(posedge clk);
		check("wr_count", 8'(rd ? n : n + 1), 8'(wr_seen));
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(50));
		foreach (mem[i]) mem[i] = 8'h00;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		for (int s = 0; s < 3; s++) begin
			style <= bus_style_t'(s);
			acc(1'b1, 5'h1F, 8'h00);
			acc(1'b0, 5'h00, 8'hA5);
			acc(1'b0, 5'h1F, 8'h5A);
			acc(1'b1, 5'h00, 8'h00);
			repeat (6) begin
				a = 5'($urandom);
				d = 8'($urandom);
				acc(1'b0, a, d);
				acc(1'b1, a, 8'h00);
				acc(1'b0, a, ~mem[a]);
				acc(1'b1, a, 8'h00);
			end
		end
		// hardware control: request must be refused, address, ale and address strobe pins low
		style <= STYLE_HWCTRL;
		seen = 1'b0;
		@(posedge clk);
		req <= 1'b1;
		repeat (20) begin
			@(posedge clk);
			req <= 1'b0;
			seen = seen | (done === 1'b1);
		end
		check("hw_done", 8'h00, {7'h00, seen});
		check("hw_addr", 8'h00, {3'h0, bus.register_address_inputs});
		check("hw_ale", 8'h00, {7'h00, bus.addr_latch_en});
		check("hw_strobe", 8'h00, {7'h00, bus.address_strobe_n});
		summarize();
	end
	// hang guard well beyond the expected run
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		summarize();
	end
endmodule
